//--- core/mft_pkg.sv
// Package for the multifunction timer: offsets, fields, counts, types
package mft_pkg;
  // Register byte addresses: index times four
  localparam logic [7:0] MFT_CSR_IDX = 8'h2D;
  localparam logic [11:0] MFT_CSR_ADDR = {2'b00, MFT_CSR_IDX, 2'b00};
  localparam logic [11:0] MFT_INT_ADDR = 12'h100;
  localparam logic [11:0] MFT_MASK_ADDR = 12'h104;
  localparam logic [11:0] MFT_SVC_ADDR = 12'h108;
  // Control and status field positions
  localparam int MFT_B_OVF = 7;
  localparam int MFT_B_PER = 6;
  localparam int MFT_B_OVFE = 5;
  localparam int MFT_B_PERE = 4;
  localparam int MFT_B_OVFC = 3;
  localparam int MFT_B_PERC = 2;
  // Event bit positions in the interrupt status and mask registers
  localparam int MFT_E_OVF = 0;
  localparam int MFT_E_PER = 1;
  localparam int MFT_E_WDG = 2;
  localparam int MFT_E_REC = 3;
  // Divider chain counts
  localparam int MFT_PRE_DIV = 5;
  localparam int MFT_RIP_BITS = 7;
  localparam int MFT_PER_DIV = 125;
  localparam int MFT_WDG_DIV = 15;
  localparam int MFT_POR_DIV = 5121;
  localparam logic [31:0] MFT_RST_VAL = 32'h0000_0000;
  typedef enum logic [1:0] {
    MFT_RUN = 2'b00,
    MFT_STOPPED = 2'b01,
    MFT_RECOVER = 2'b10
  } mft_mode_t;
  typedef struct packed {
    logic ovf_tick;
    logic pwm_pre;
    logic pwm_128;
    logic por_tick;
  } mft_taps_t;
  typedef struct packed {
    mft_mode_t mode;
    logic [2:0] pre;
    logic [6:0] rip;
    logic [6:0] per;
    logic [3:0] wdg;
    logic [12:0] por;
    logic [12:0] rec;
    logic ovf_flag;
    logic per_flag;
    logic ovf_en;
    logic per_en;
    logic [3:0] int_stat;
    logic [3:0] int_mask;
    logic wdg_rst;
    logic pwm_128;
    mft_taps_t taps;
    logic [31:0] prdata;
  } mft_state_t;
endpackage

//--- core/mft_timer.sv
// Multifunction timer with periodic tick, watchdog and APB registers
// What this block does
// - Divide-by-five prescaler clocks 7-bit counter, overflow every 640 cycles
// - Divide-by-125 after overflow gives periodic tick every 80000 cycles
// - Bus clock divided by 5121 gives a reference tap and times stop recovery
// - Prescaler output and divide-by-128 tap go to the modulator
// - Overflow sets overflow flag; irq while flag and enable set
// - Periodic tick sets periodic flag; irq while flag and enable set
// - Writing one to overflow clear bit clears flag; reads zero
// - Writing one to periodic clear bit clears flag; reads zero
// - Software writes to both flags are ignored
// - Reset clears flags and enables; clear bits hold no state
// - Counting continues in wait; enabled irq wakes processor
// - Entering stop clears chain, flags and enables
// - Leaving stop waits recovery delay, clears chain, resumes
// - Tick divided by 15 gives watchdog timeout and internal reset
// - Writing zero to service bit 0 clears only the last stage
// - Watchdog present or absent by a build parameter
// - Overflow and periodic requests share one interrupt line
//
// Implementation choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module mft_timer #(
  parameter bit WDG_PRESENT = 1'b1,
  parameter int POR_DIV = mft_pkg::MFT_POR_DIV
) (
  input wire logic pclk, // Bus clock
  input wire logic presetn, // Async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic stop_req, // Stop mode entry
  input wire logic stop_wake, // External wake from stop
  output logic cpu_irq, // Shared timer request
  output logic wake_req, // Wait exit request
  output logic irq, // Masked event interrupt
  output logic wdg_reset, // Internal watchdog reset
  output mft_pkg::mft_taps_t taps // Timing taps
);
  import mft_pkg::*;

  mft_state_t s_reg;
  mft_state_t s_next;
  logic wr;
  logic rd;
  logic en_chain;
  logic pre_tc;
  logic ovf_tc;
  logic per_tc;
  logic por_tc;
  logic ack_reg;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    hit = (a == b);
  endfunction

  // Writes act only at the ready edge, so a W1C clear
  // still swallows an event that lands in the first access cycle
  assign wr = psel && penable && pwrite && ack_reg;
  assign rd = psel && penable && !pwrite;
  assign en_chain = (s_reg.mode == MFT_RUN);
  assign pre_tc = en_chain && (s_reg.pre == 3'(MFT_PRE_DIV - 1));
  assign ovf_tc = pre_tc && (s_reg.rip == 7'h7F);
  assign per_tc = ovf_tc && (s_reg.per == 7'(MFT_PER_DIV - 1));
  assign por_tc = (s_reg.por == 13'(POR_DIV - 1));

  always_comb begin
    s_next = s_reg;
    s_next.taps = '0;
    s_next.prdata = s_reg.prdata;
    s_next.wdg_rst = 1'b0;
    // Free-running divide-by-5121 reference
    s_next.por = por_tc ? 13'h0000 : 13'(s_reg.por + 13'h0001);
    s_next.taps.por_tick = por_tc;
    if (en_chain) begin
      // Chain keeps running in wait; only stop and the recovery delay halt it
      s_next.pre = pre_tc ? 3'h0 : 3'(s_reg.pre + 3'h1);
      if (pre_tc) begin
        s_next.rip = 7'(s_reg.rip + 7'h01);
        if (ovf_tc) begin
          s_next.per = per_tc ? 7'h00 : 7'(s_reg.per + 7'h01);
        end
        // Square wave of bit 6: toggles every 64 prescaler ticks
        if (s_reg.rip[5:0] == 6'h3F) begin
          s_next.pwm_128 = ~s_reg.pwm_128;
        end
      end
      if (per_tc && WDG_PRESENT) begin
        if (s_reg.wdg == 4'(MFT_WDG_DIV - 1)) begin
          s_next.wdg = 4'h0;
          s_next.wdg_rst = 1'b1;
        end else begin
          s_next.wdg = 4'(s_reg.wdg + 4'h1);
        end
      end
    end
    s_next.taps.pwm_pre = pre_tc;
    s_next.taps.pwm_128 = s_next.pwm_128;
    s_next.taps.ovf_tick = ovf_tc;
    // Flags: clear bits act only on a one; set beats clear
    if (wr && hit(paddr, MFT_CSR_ADDR)) begin
      s_next.ovf_en = pwdata[MFT_B_OVFE];
      s_next.per_en = pwdata[MFT_B_PERE];
      if (pwdata[MFT_B_OVFC]) begin
        s_next.ovf_flag = 1'b0;
      end
      if (pwdata[MFT_B_PERC]) begin
        s_next.per_flag = 1'b0;
      end
    end
    if (ovf_tc) begin
      s_next.ovf_flag = 1'b1;
    end
    if (per_tc) begin
      s_next.per_flag = 1'b1;
    end
    if (wr && hit(paddr, MFT_INT_ADDR)) begin
      s_next.int_stat = s_reg.int_stat & ~pwdata[3:0];
    end
    if (wr && hit(paddr, MFT_MASK_ADDR)) begin
      s_next.int_mask = pwdata[3:0];
    end
    if (wr && hit(paddr, MFT_SVC_ADDR) && !pwdata[0] && WDG_PRESENT) begin
      s_next.wdg = 4'h0;
    end
    if (ovf_tc) begin
      s_next.int_stat[MFT_E_OVF] = 1'b1;
    end
    if (per_tc) begin
      s_next.int_stat[MFT_E_PER] = 1'b1;
    end
    if (s_next.wdg_rst) begin
      s_next.int_stat[MFT_E_WDG] = 1'b1;
    end
    // Low-power sequencing
    case (s_reg.mode)
      MFT_RUN: begin
        if (stop_req) begin
          s_next.mode = MFT_STOPPED;
          s_next.pre = 3'h0;
          s_next.rip = 7'h00;
          s_next.per = 7'h00;
          s_next.wdg = 4'h0;
          s_next.ovf_flag = 1'b0;
          s_next.per_flag = 1'b0;
          s_next.ovf_en = 1'b0;
          s_next.per_en = 1'b0;
        end
      end
      MFT_STOPPED: begin
        if (stop_wake) begin
          s_next.mode = MFT_RECOVER;
          s_next.rec = 13'h0000;
        end
      end
      MFT_RECOVER: begin
        // Recovery delay is one full 5121-cycle period
        if (s_reg.rec == 13'(POR_DIV - 1)) begin
          s_next.mode = MFT_RUN;
          s_next.pre = 3'h0;
          s_next.rip = 7'h00;
          s_next.per = 7'h00;
          s_next.wdg = 4'h0;
          s_next.int_stat[MFT_E_REC] = 1'b1;
        end else begin
          s_next.rec = 13'(s_reg.rec + 13'h0001);
        end
      end
      default: begin
        s_next.mode = MFT_RUN;
      end
    endcase
    if (rd) begin
      s_next.prdata = 32'h0000_0000;
      if (hit(paddr, MFT_CSR_ADDR)) begin
        // Clear bits and low nibble read as zero
        s_next.prdata[MFT_B_OVF] = s_reg.ovf_flag;
        s_next.prdata[MFT_B_PER] = s_reg.per_flag;
        s_next.prdata[MFT_B_OVFE] = s_reg.ovf_en;
        s_next.prdata[MFT_B_PERE] = s_reg.per_en;
      end else if (hit(paddr, MFT_INT_ADDR)) begin
        s_next.prdata[3:0] = s_reg.int_stat;
      end else if (hit(paddr, MFT_MASK_ADDR)) begin
        s_next.prdata[3:0] = s_reg.int_mask;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Read data is registered, so each access takes one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= psel && penable && !ack_reg;
    end
  end

  assign pready = ack_reg;
  assign pslverr = 1'b0;
  assign prdata = s_reg.prdata;
  assign cpu_irq = (s_reg.ovf_flag && s_reg.ovf_en) ||
                   (s_reg.per_flag && s_reg.per_en);
  assign wake_req = cpu_irq;
  assign irq = |(s_reg.int_stat & s_reg.int_mask);
  assign wdg_reset = s_reg.wdg_rst;
  assign taps = s_reg.taps;

  // Checks: flags and interrupt request
  a_ovf_sets: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ovf_tc && !stop_req) |=> s_reg.ovf_flag)
    else $error("overflow flag not set");
  a_per_sets: assert property (
    @(posedge pclk) disable iff (!presetn)
    (per_tc && !stop_req) |=> s_reg.per_flag)
    else $error("periodic flag not set");
  a_irq_shared: assert property (
    @(posedge pclk) disable iff (!presetn)
    cpu_irq == ((s_reg.ovf_flag && s_reg.ovf_en) ||
    (s_reg.per_flag && s_reg.per_en))) else $error("bad irq");
  a_ovf_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr && paddr == MFT_CSR_ADDR && pwdata[MFT_B_OVFC] && !ovf_tc)
    |=> !s_reg.ovf_flag) else $error("overflow not cleared");
  a_per_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr && paddr == MFT_CSR_ADDR && pwdata[MFT_B_PERC] && !per_tc)
    |=> !s_reg.per_flag) else $error("periodic not cleared");
  a_flag_ro: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!s_reg.ovf_flag && !ovf_tc && s_reg.mode == MFT_RUN)
    |=> !s_reg.ovf_flag) else $error("flag set by software");
  a_per_ro: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!s_reg.per_flag && !per_tc && s_reg.mode == MFT_RUN)
    |=> !s_reg.per_flag) else $error("periodic set by software");
  a_csr_clear_bits: assert property (
    @(posedge pclk) disable iff (!presetn)
    (rd && paddr == MFT_CSR_ADDR) |=> prdata[3:0] == 4'h0)
    else $error("clear bits read back nonzero");
  a_wake_irq: assert property (
    @(posedge pclk) disable iff (!presetn)
    wake_req == cpu_irq)
    else $error("wake request differs from irq");

  // Checks: divider chain and taps
  a_pre_gap: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pre_tc && s_reg.mode == MFT_RUN && !stop_req) |=> !pre_tc [*4])
    else $error("prescaler not divide by five");
  a_ovf_single: assert property (
    @(posedge pclk) disable iff (!presetn)
    ovf_tc |=> !ovf_tc)
    else $error("overflow longer than one cycle");
  a_ovf_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    ovf_tc |=> s_reg.rip == 7'h00)
    else $error("counter did not roll to zero");
  a_per_on_ovf: assert property (
    @(posedge pclk) disable iff (!presetn)
    per_tc |-> ovf_tc)
    else $error("periodic tick without overflow");
  a_tick_single: assert property (
    @(posedge pclk) disable iff (!presetn)
    per_tc |=> !per_tc)
    else $error("tick longer than one");
  a_pre_tap: assert property (
    @(posedge pclk) disable iff (!presetn)
    pre_tc |=> taps.pwm_pre)
    else $error("prescaler tap missing");
  a_pwm_toggle: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pre_tc && s_reg.rip[5:0] == 6'h3F)
    |=> s_reg.pwm_128 != $past(s_reg.pwm_128))
    else $error("divide by 128 tap did not toggle");
  a_pwm_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(pre_tc && s_reg.rip[5:0] == 6'h3F) |=> $stable(s_reg.pwm_128))
    else $error("divide by 128 tap toggled early");
  a_por_range: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_reg.por < 13'(POR_DIV))
    else $error("reference counter out of range");
  a_por_tap: assert property (
    @(posedge pclk) disable iff (!presetn)
    por_tc |=> taps.por_tick)
    else $error("reference tick missing");

  // Checks: low-power sequencing
  a_stop_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_reg.mode == MFT_RUN && stop_req) |=> (!s_reg.ovf_en &&
    !s_reg.per_en && !cpu_irq && s_reg.rip == 7'h00))
    else $error("stop did not clear");
  a_stop_halts: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_reg.mode == MFT_STOPPED |-> !pre_tc)
    else $error("chain ran while stopped");
  a_stop_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_reg.mode == MFT_STOPPED |-> (!s_reg.ovf_flag && !s_reg.per_flag))
    else $error("flag pending while stopped");
  a_recover_range: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_reg.mode == MFT_RECOVER |-> s_reg.rec < 13'(POR_DIV))
    else $error("recovery count out of range");
  a_recover_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s_reg.mode == MFT_RECOVER && s_reg.rec == 13'(POR_DIV - 1))
    |=> (s_reg.mode == MFT_RUN && s_reg.rip == 7'h00 && s_reg.pre == 3'h0))
    else $error("chain not cleared on resume");

  // Checks: watchdog
  a_svc_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr && paddr == MFT_SVC_ADDR && !pwdata[0] && WDG_PRESENT)
    |=> s_reg.wdg == 4'h0) else $error("service failed");
  a_svc_keeps: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr && paddr == MFT_SVC_ADDR && !pre_tc && !stop_req &&
    s_reg.mode == MFT_RUN) |=> ($stable(s_reg.rip) && $stable(s_reg.per)))
    else $error("service disturbed earlier stages");
  a_wdg_fire: assert property (
    @(posedge pclk) disable iff (!presetn)
    wdg_reset |-> $past(s_reg.wdg) == 4'(MFT_WDG_DIV - 1))
    else $error("early watchdog");
  a_wdg_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    wdg_reset |=> !wdg_reset)
    else $error("watchdog reset longer than one cycle");
  a_wdg_range: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_reg.wdg < 4'(MFT_WDG_DIV))
    else $error("watchdog count out of range");
  a_wdg_absent: assert property (
    @(posedge pclk) disable iff (!presetn)
    !WDG_PRESENT |-> (s_reg.wdg == 4'h0 && !wdg_reset))
    else $error("watchdog active though left out");

  // Checks: bus
  a_ready_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready longer than one cycle");
  a_slverr_low: assert property (
    @(posedge pclk) disable iff (!presetn)
    !pslverr)
    else $error("error response raised");

  c_ovf: cover property (
    @(posedge pclk) disable iff (!presetn) ovf_tc);
  c_per: cover property (
    @(posedge pclk) disable iff (!presetn) per_tc);
  c_stop: cover property (@(posedge pclk) disable iff (!presetn)
    s_reg.mode == MFT_RECOVER ##1 s_reg.mode == MFT_RUN);
  c_irq: cover property (
    @(posedge pclk) disable iff (!presetn) cpu_irq);
  c_svc: cover property (@(posedge pclk) disable iff (!presetn)
    wr && paddr == MFT_SVC_ADDR && !pwdata[0]);
endmodule
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the multifunction timer
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import mft_pkg::*;
  localparam int POR = 8;
  `define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    fails++; $display("unexpected %s exp %0h got %0h", nm, e, g); end end
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic stop_req = 1'b0;
  logic stop_wake = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, cpu_irq, wake_req, irq, wdg_reset;
  mft_taps_t taps;
  logic [31:0] exp_q[$];
  logic [31:0] exp_v;
  logic p128 = 1'b0;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int n_ovf = 0;
  int n_wdg = 0;
  int t_ovf = 0;
  int t_128 = 0;
  int t_pre = 0;
  int t_por = 0;
  int t_wake;
  int n;

  mft_timer #(.WDG_PRESENT(1'b1), .POR_DIV(POR)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stop_req(stop_req),
    .stop_wake(stop_wake), .cpu_irq(cpu_irq), .wake_req(wake_req),
    .irq(irq), .wdg_reset(wdg_reset), .taps(taps));

  initial begin
    forever #20 pclk = ~pclk;
  end

  task automatic conclude();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic wait_ovf();
    int k;
    k = n_ovf;
    while (n_ovf == k) @(negedge pclk);
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc > 95000) begin
      fails++;
      conclude();
    end
  end

  // Result watcher and tap timing monitor, at the sampling edge
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hDEAD_BEEF;
      `CHK("prdata", exp_v, prdata)
      `CHK("pslverr", 1'b0, pslverr)
    end
    if (taps.pwm_pre === 1'b1) begin
      if (t_pre != 0) `CHK("pwm_pre", 5, cyc - t_pre)
      t_pre = cyc;
    end
    if (taps.por_tick === 1'b1) begin
      if (t_por != 0) `CHK("por_tick", POR, cyc - t_por)
      t_por = cyc;
    end
    if (wdg_reset === 1'b1) n_wdg++;
    if (taps.ovf_tick === 1'b1) begin
      n_ovf++;
      if (t_ovf != 0) `CHK("ovf_period", 640, cyc - t_ovf)
      t_ovf = cyc;
    end
    if (taps.pwm_128 !== p128) begin
      if (t_128 != 0) `CHK("pwm_128", 320, cyc - t_128)
      t_128 = cyc;
      p128 = taps.pwm_128;
    end
  end

  initial begin
    void'($urandom(32'h9541));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(MFT_CSR_ADDR, 32'h0000_0000);
    rd(MFT_INT_ADDR, 32'h0000_0000);
    apb(1'b1, 12'h0F0, $urandom());
    rd(12'h0F0, 32'h0000_0000);
    wait_ovf();
    rd(MFT_CSR_ADDR, 32'h0000_0080);
    `CHK("cpu_irq", 1'b0, cpu_irq)
    // Flag bits written high must not stick
    apb(1'b1, MFT_CSR_ADDR, 32'h0000_00E0);
    rd(MFT_CSR_ADDR, 32'h0000_00A0);
    `CHK("cpu_irq", 1'b1, cpu_irq)
    `CHK("wake_req", 1'b1, wake_req)
    apb(1'b1, MFT_CSR_ADDR, 32'h0000_0020);
    rd(MFT_CSR_ADDR, 32'h0000_00A0);
    apb(1'b1, MFT_CSR_ADDR, 32'h0000_0028);
    rd(MFT_CSR_ADDR, 32'h0000_0020);
    `CHK("cpu_irq", 1'b0, cpu_irq)
    apb(1'b1, MFT_MASK_ADDR, 32'h0000_0001);
    wait_ovf();
    `CHK("irq", 1'b1, irq)
    rd(MFT_INT_ADDR, 32'h0000_0001);
    apb(1'b1, MFT_MASK_ADDR, 32'h0000_0000);
    @(negedge pclk);
    `CHK("irq", 1'b0, irq)
    apb(1'b1, MFT_INT_ADDR, 32'h0000_0001);
    rd(MFT_INT_ADDR, 32'h0000_0000);
    apb(1'b1, MFT_CSR_ADDR, 32'h0000_0030);
    // Periodic tick lands on the 125th overflow
    while (n_ovf < 125) wait_ovf();
    rd(MFT_CSR_ADDR, 32'h0000_00F0);
    rd(MFT_INT_ADDR, 32'h0000_0003);
    apb(1'b1, MFT_CSR_ADDR, 32'h0000_0034);
    rd(MFT_CSR_ADDR, 32'h0000_00B0);
    `CHK("cpu_irq", 1'b1, cpu_irq)
    apb(1'b1, MFT_INT_ADDR, 32'h0000_000F);
    apb(1'b1, MFT_SVC_ADDR, 32'h0000_0000);
    @(posedge pclk);
    stop_req <= 1'b1;
    t_ovf = 0;
    t_128 = 0;
    @(posedge pclk);
    stop_req <= 1'b0;
    rd(MFT_CSR_ADDR, 32'h0000_0000);
    `CHK("cpu_irq", 1'b0, cpu_irq)
    n = n_ovf;
    repeat (700) @(posedge pclk);
    `CHK("stopped_ovf", n, n_ovf)
    stop_wake <= 1'b1;
    t_wake = cyc;
    t_128 = 0;
    t_pre = 0;
    t_ovf = 0;
    @(posedge pclk);
    stop_wake <= 1'b0;
    repeat (30) @(posedge pclk);
    rd(MFT_INT_ADDR, 32'h0000_0008);
    wait_ovf();
    n = cyc - t_wake;
    `CHK("resume_delay", 1'b1, n >= 640 + POR && n <= 656 + POR)
    `CHK("wdg_pulses", 0, n_wdg)
    `CHK("queue_left", 0, exp_q.size())
    conclude();
  end
endmodule
`default_nettype wire
